// file: inc/gpm_pkg.sv
/*
  gpm_pkg: register map, field layout and function codes of the eight-pin port.
  Assumes a 32-bit AHB-Lite register bus; every register is one aligned word.
*/
package gpm_pkg;
  localparam int GPM_PINS = 8;
  localparam int GPM_AW = 8;
  localparam logic [7:0] GPM_OFF_CFG = 8'h00;
  localparam logic [7:0] GPM_OFF_OEN = 8'h04;
  localparam logic [7:0] GPM_OFF_PULL = 8'h08;
  localparam logic [7:0] GPM_OFF_IEN = 8'h0c;
  localparam logic [7:0] GPM_OFF_IN = 8'h10;
  localparam logic [7:0] GPM_OFF_OUT = 8'h14;
  localparam logic [7:0] GPM_OFF_SET = 8'h18;
  localparam logic [7:0] GPM_OFF_CLR = 8'h1c;
  localparam logic [7:0] GPM_OFF_TGL = 8'h20;
  localparam logic [7:0] GPM_OFF_EVCFG = 8'h24;
  localparam logic [7:0] GPM_OFF_EVCLR = 8'h28;
  localparam logic [7:0] GPM_OFF_EVFLG = 8'h2c;
  localparam logic [15:0] GPM_RST_CFG = 16'h0000;
  localparam logic [7:0] GPM_RST_BYTE = 8'h00;
  localparam logic [31:0] GPM_ZERO32 = 32'h0000_0000;
  localparam int GPM_FW = 2;
  // per-pin event config nibble: [1:0] edge mode, [2] wake, [3] trigger sequence
  localparam int GPM_EW = 4;
  localparam logic [1:0] GPM_EV_RISE = 2'h0;
  localparam logic [1:0] GPM_EV_FALL = 2'h1;
  localparam logic [1:0] GPM_EV_BOTH = 2'h2;
  localparam logic [1:0] GPM_EV_HIGH = 2'h3;
  localparam int GPM_EV_WAKE_BIT = 2;
  localparam int GPM_EV_SEQ_BIT = 3;
  localparam logic [1:0] GPM_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] GPM_FN_00 = 2'h0;
  localparam logic [1:0] GPM_FN_01 = 2'h1;
  localparam logic [1:0] GPM_FN_10 = 2'h2;
  localparam logic [1:0] GPM_FN_11 = 2'h3;
  // what a pin does for one function code
  typedef enum logic [2:0] {
    GPM_SRC_GPIO = 3'h0,
    GPM_SRC_TRIG = 3'h1,
    GPM_SRC_SYNC = 3'h2,
    GPM_SRC_IRQ0 = 3'h3,
    GPM_SRC_IRQ1 = 3'h4,
    GPM_SRC_POR = 3'h5,
    GPM_SRC_HIB = 3'h6,
    GPM_SRC_CLK = 3'h7
  } gpm_src_e;
endpackage : gpm_pkg

// file: rtl/gpm_port.sv
/*
  gpm_port: eight-pin general-purpose port with per-pin function multiplexer,
  event detection and an AHB-Lite register slave.
  Assumes pins, sequencer, interrupt and power inputs are synchronous to hclk;
  the pad ring resolves pin levels from pin_out and pin_oe.
*/
`timescale 1ns/10ps
module gpm_port
  import gpm_pkg::*;
#(
  parameter int NPINS = GPM_PINS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_pull_en,
  input wire logic [NPINS-1:0] sequencer_sync_outputs,
  input wire logic irq0_pending,
  input wire logic irq1_pending,
  input wire logic por_level,
  input wire logic hibernate_flag,
  output logic [3:0] seq_trigger,
  output logic external_clock_input,
  output logic [NPINS-1:0] event_wake,
  output logic [NPINS-1:0] event_seq_start
);

  typedef struct packed {
    logic [15:0] pin_function_config;
    logic [7:0] output_enable;
    logic [7:0] pull_enable;
    logic [7:0] input_path_enable;
    logic [7:0] pin_input_data;
    logic [7:0] output_data;
    logic [31:0] event_detect_config;
    logic [7:0] event_flags;
    logic [7:0] pin_prev;
    logic [7:0] wake;
    logic [7:0] seq_start;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic armed;
  } gpm_state_s;

  gpm_state_s cur;
  gpm_state_s nxt;

  gpm_src_e src [NPINS];
  logic [7:0] det;
  logic [31:0] next_rdata;

  // fixed function table per pin and code
  function automatic gpm_src_e fn_map(input int pin, input logic [1:0] code);
    gpm_src_e s;
    s = GPM_SRC_GPIO;
    if (code == GPM_FN_01) begin
      s = GPM_SRC_TRIG;
    end else if (code == GPM_FN_10) begin
      s = GPM_SRC_SYNC;
    end else begin
      case (pin)
        0: s = (code == GPM_FN_00) ? GPM_SRC_IRQ0 : GPM_SRC_GPIO;
        1: s = (code == GPM_FN_00) ? GPM_SRC_GPIO : GPM_SRC_HIB;
        2: s = (code == GPM_FN_00) ? GPM_SRC_POR : GPM_SRC_CLK;
        3: s = (code == GPM_FN_00) ? GPM_SRC_GPIO : GPM_SRC_IRQ0;
        4: s = (code == GPM_FN_00) ? GPM_SRC_GPIO : GPM_SRC_IRQ1;
        5: s = (code == GPM_FN_00) ? GPM_SRC_GPIO : GPM_SRC_CLK;
        6: s = (code == GPM_FN_00) ? GPM_SRC_GPIO : GPM_SRC_IRQ0;
        7: s = (code == GPM_FN_00) ? GPM_SRC_GPIO : GPM_SRC_IRQ1;
        default: s = GPM_SRC_GPIO;
      endcase
    end
    return s;
  endfunction : fn_map

  // decode and output mux per pin
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    logic [3:0] ecfg;
    assign src[i] = fn_map(i, cur.pin_function_config[GPM_FW*i +: GPM_FW]);
    assign ecfg = cur.event_detect_config[GPM_EW*i +: GPM_EW];
    // edge/level detector on live pin_in against the registered pin_prev, no extra synchroniser needed;
    // held off for the first cycle after reset so a pin already high is no fresh edge
    always_comb begin
      det[i] = 1'b0;
      if (cur.armed) begin
        case (ecfg[1:0])
          GPM_EV_RISE: det[i] = pin_in[i] & ~cur.pin_prev[i];
          GPM_EV_FALL: det[i] = ~pin_in[i] & cur.pin_prev[i];
          GPM_EV_BOTH: det[i] = pin_in[i] ^ cur.pin_prev[i];
          default: det[i] = pin_in[i];
        endcase
      end
    end
    // driver source chosen by function field
    always_comb begin
      case (src[i])
        GPM_SRC_SYNC: pin_out[i] = sequencer_sync_outputs[i];
        GPM_SRC_IRQ0: pin_out[i] = irq0_pending;
        GPM_SRC_IRQ1: pin_out[i] = irq1_pending;
        GPM_SRC_POR: pin_out[i] = por_level;
        GPM_SRC_HIB: pin_out[i] = hibernate_flag;
        GPM_SRC_GPIO: pin_out[i] = cur.output_data[i];
        default: pin_out[i] = 1'b0;
      endcase
    end
    // dedicated outputs drive always; inputs never; gpio and sync need enable
    assign pin_oe[i] = (src[i] == GPM_SRC_IRQ0) || (src[i] == GPM_SRC_IRQ1)
                       || (src[i] == GPM_SRC_POR) || (src[i] == GPM_SRC_HIB)
                       || (((src[i] == GPM_SRC_GPIO) || (src[i] == GPM_SRC_SYNC))
                           && cur.output_enable[i]);
  end

  // trigger inputs: pins 0-3 and 4-7 map to sequences 0-3
  always_comb begin
    seq_trigger = 4'h0;
    external_clock_input = 1'b0;
    for (int i = 0; i < NPINS; i++) begin
      if (src[i] == GPM_SRC_TRIG) begin
        seq_trigger[i % 4] = seq_trigger[i % 4] | pin_in[i];
      end
      if (src[i] == GPM_SRC_CLK) begin
        external_clock_input = external_clock_input | pin_in[i];
      end
    end
  end

  assign pin_pull_en = cur.pull_enable;
  assign event_wake = cur.wake;
  assign event_seq_start = cur.seq_start;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = cur.rdata;

  logic addr_ok;
  assign addr_ok = hsel && hready && (htrans == GPM_HTRANS_NONSEQ);

  // read mux; write-only registers read zero
  always_comb begin
    next_rdata = GPM_ZERO32;
    case (haddr[GPM_AW-1:0])
      GPM_OFF_CFG: next_rdata = {16'h0000, cur.pin_function_config};
      GPM_OFF_OEN: next_rdata = {24'h000000, cur.output_enable};
      GPM_OFF_PULL: next_rdata = {24'h000000, cur.pull_enable};
      GPM_OFF_IEN: next_rdata = {24'h000000, cur.input_path_enable};
      GPM_OFF_IN: next_rdata = {24'h000000, cur.pin_input_data};
      GPM_OFF_OUT: next_rdata = {24'h000000, cur.output_data};
      GPM_OFF_EVCFG: next_rdata = cur.event_detect_config;
      GPM_OFF_EVFLG: next_rdata = {24'h000000, cur.event_flags};
      default: next_rdata = GPM_ZERO32;
    endcase
  end

  // next-state: bus writes land in the data phase, one cycle after address
  always_comb begin
    logic [7:0] wd;
    logic [7:0] evclr;
    wd = hwdata[7:0];
    evclr = 8'h00;
    nxt = cur;
    nxt.armed = 1'b1; // pin_prev holds a real sample from here on
    nxt.dp_wr = addr_ok && hwrite;
    nxt.dp_addr = haddr[GPM_AW-1:0];
    if (addr_ok && !hwrite) begin
      nxt.rdata = next_rdata;
    end
    nxt.pin_input_data = pin_in & cur.input_path_enable;
    nxt.pin_prev = pin_in;
    if (cur.dp_wr) begin
      case (cur.dp_addr)
        GPM_OFF_CFG: nxt.pin_function_config = hwdata[15:0];
        GPM_OFF_OEN: nxt.output_enable = wd;
        GPM_OFF_PULL: nxt.pull_enable = wd;
        GPM_OFF_IEN: nxt.input_path_enable = wd;
        GPM_OFF_OUT: nxt.output_data = wd;
        GPM_OFF_SET: nxt.output_data = cur.output_data | wd;
        GPM_OFF_CLR: nxt.output_data = cur.output_data & ~wd;
        GPM_OFF_TGL: nxt.output_data = cur.output_data ^ wd;
        GPM_OFF_EVCFG: nxt.event_detect_config = hwdata;
        GPM_OFF_EVCLR: evclr = wd;
        default: evclr = 8'h00;
      endcase
    end
    // a new detection in the clearing cycle wins over the clear
    nxt.event_flags = (cur.event_flags & ~evclr) | det;
    for (int i = 0; i < NPINS; i++) begin
      nxt.wake[i] = det[i] & cur.event_detect_config[GPM_EW*i + GPM_EV_WAKE_BIT];
      nxt.seq_start[i] = det[i] & cur.event_detect_config[GPM_EW*i + GPM_EV_SEQ_BIT];
    end
  end

  // state register, all zero after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  property p_set_only_ones;
    @(posedge hclk) disable iff (!hresetn)
    (cur.dp_wr && cur.dp_addr == GPM_OFF_SET) |=> cur.output_data == ($past(cur.output_data) | $past(hwdata[7:0]));
  endproperty
  a_set_only_ones: assert property (p_set_only_ones) else $error("set register wrong");

  property p_clr_only_ones;
    @(posedge hclk) disable iff (!hresetn)
    (cur.dp_wr && cur.dp_addr == GPM_OFF_CLR) |=> cur.output_data == ($past(cur.output_data) & ~$past(hwdata[7:0]));
  endproperty
  a_clr_only_ones: assert property (p_clr_only_ones) else $error("clear register wrong");

  property p_input_gated;
    @(posedge hclk) disable iff (!hresetn)
    ##1 (cur.pin_input_data == ($past(pin_in) & $past(cur.input_path_enable)));
  endproperty
  a_input_gated: assert property (p_input_gated) else $error("input sample not gated");

  property p_gpio_drive;
    @(posedge hclk) disable iff (!hresetn)
    (src[0] == GPM_SRC_GPIO && cur.output_enable[0]) |-> (pin_oe[0] && pin_out[0] == cur.output_data[0]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("pin 0 not driving output data");

  property p_sync_needs_oe;
    @(posedge hclk) disable iff (!hresetn)
    (src[4] == GPM_SRC_SYNC && !cur.output_enable[4]) |-> !pin_oe[4];
  endproperty
  a_sync_needs_oe: assert property (p_sync_needs_oe) else $error("sync drove without enable");

  property p_irq_high;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[15:14] == GPM_FN_11 && irq1_pending) |-> (pin_oe[7] && pin_out[7]);
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("pin 7 not high on irq1");

  property p_irq_low;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[1:0] == GPM_FN_00 && !irq0_pending) |-> !pin_out[0];
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("pin 0 not low after irq0 clear");

  property p_evclr;
    @(posedge hclk) disable iff (!hresetn)
    (cur.dp_wr && cur.dp_addr == GPM_OFF_EVCLR && hwdata[0] && !det[0]) |=> !cur.event_flags[0];
  endproperty
  a_evclr: assert property (p_evclr) else $error("event flag 0 not cleared");

  property p_pull;
    @(posedge hclk) disable iff (!hresetn)
    (cur.dp_wr && cur.dp_addr == GPM_OFF_PULL) |=> pin_pull_en == $past(hwdata[7:0]);
  endproperty
  a_pull: assert property (p_pull) else $error("pull enable not updated");

  property p_wake_pulse;
    @(posedge hclk) disable iff (!hresetn)
    (det[4] && cur.event_detect_config[GPM_EW*4 + GPM_EV_WAKE_BIT]) |=> event_wake[4];
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("pin 4 event gave no wake pulse");

  property p_seq_pulse;
    @(posedge hclk) disable iff (!hresetn)
    (det[6] && cur.event_detect_config[GPM_EW*6 + GPM_EV_SEQ_BIT]) |=> event_seq_start[6];
  endproperty
  a_seq_pulse: assert property (p_seq_pulse) else $error("pin 6 event gave no sequence start");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
    det[5] |=> cur.event_flags[5];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("pin 5 event flag lost");

  property p_pin0_gpio;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[GPM_FW*0 +: GPM_FW] == GPM_FN_11) |-> (pin_oe[0] == cur.output_enable[0]);
  endproperty
  a_pin0_gpio: assert property (p_pin0_gpio) else $error("pin 0 general I/O enable wrong");

  property p_pin1_hib;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[GPM_FW*1 +: GPM_FW] == GPM_FN_11) |-> (pin_oe[1] && pin_out[1] == hibernate_flag);
  endproperty
  a_pin1_hib: assert property (p_pin1_hib) else $error("pin 1 not showing hibernate flag");

  property p_pin1_trig;
    @(posedge hclk) disable iff (!hresetn)
    (src[1] == GPM_SRC_TRIG) |-> (!pin_oe[1] && (seq_trigger[1] || !pin_in[1]));
  endproperty
  a_pin1_trig: assert property (p_pin1_trig) else $error("pin 1 trigger input wrong");

  property p_pin2_por;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[GPM_FW*2 +: GPM_FW] == GPM_FN_00) |-> (pin_oe[2] && pin_out[2] == por_level);
  endproperty
  a_pin2_por: assert property (p_pin2_por) else $error("pin 2 not showing reset level");

  property p_pin3_irq0;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[GPM_FW*3 +: GPM_FW] == GPM_FN_11 && irq0_pending) |-> (pin_oe[3] && pin_out[3]);
  endproperty
  a_pin3_irq0: assert property (p_pin3_irq0) else $error("pin 3 not high on irq0");

  property p_pin4_irq1;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[GPM_FW*4 +: GPM_FW] == GPM_FN_11 && irq1_pending) |-> (pin_oe[4] && pin_out[4]);
  endproperty
  a_pin4_irq1: assert property (p_pin4_irq1) else $error("pin 4 not high on irq1");

  property p_pin5_clk;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[GPM_FW*5 +: GPM_FW] == GPM_FN_11 && pin_in[5]) |-> (external_clock_input && !pin_oe[5]);
  endproperty
  a_pin5_clk: assert property (p_pin5_clk) else $error("pin 5 clock input not passed");

  property p_pin6_irq0_low;
    @(posedge hclk) disable iff (!hresetn)
    (cur.pin_function_config[GPM_FW*6 +: GPM_FW] == GPM_FN_11 && !irq0_pending) |-> (pin_oe[6] && !pin_out[6]);
  endproperty
  a_pin6_irq0_low: assert property (p_pin6_irq0_low) else $error("pin 6 not low with irq0 clear");

endmodule : gpm_port

// file: test/gpm_pad_model.sv
/*
  gpm_pad_model: pad ring and host side of the eight-pin port.
  Assumes the bench sets host_drive and host_en; one clock, hclk.
*/
`timescale 1ns/10ps
module gpm_pad_model (
  input wire logic hclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pull_en,
  input wire logic [7:0] host_drive,
  input wire logic [7:0] host_en,
  output logic [7:0] pin_in
);
  logic [7:0] churn = 8'h5a;
  // a floating pin wanders so a stale level never passes for a real one
  always @(posedge hclk) begin
    churn <= ~churn;
  end
  // device wins while driving, then host, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : host_en[i] ? host_drive[i] : pin_pull_en[i] | churn[i];
    end
  end
endmodule : gpm_pad_model

// file: test/testbench.sv
/*
  testbench: self-checking bench for gpm_port with a pad model.
  Assumes gpm_pkg is compiled first; AHB-Lite single-slave bus.
*/
`timescale 1ns/10ps
module testbench;
  import gpm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pull_en, sync, host_drive, host_en, ev_wake, ev_seq, a;
  logic irq0, irq1, por, hib, ext_clk;
  logic [3:0] seq_trigger;
  logic [15:0] m_cfg;
  logic [7:0] m_oen, m_out;
  logic [31:0] seed = 32'h0001_5182;
  int errors = 0;
  int num_checks = 0;
  int k;
  // source per pin and code, three bits each, pin 7 leftmost
  localparam logic [95:0] TBL = {12'h888, 12'h688, 12'he88, 12'h888, 12'h688, 12'he8d, 12'hc88, 12'h08b};
  gpm_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .sequencer_sync_outputs(sync),
    .irq0_pending(irq0), .irq1_pending(irq1), .por_level(por), .hibernate_flag(hib), .seq_trigger(seq_trigger),
    .external_clock_input(ext_clk), .event_wake(ev_wake), .event_seq_start(ev_seq));
  gpm_pad_model PADS (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
    .host_drive(host_drive), .host_en(host_en), .pin_in(pin_in));
  // 250 MHz clock
  initial begin
    forever #2 hclk = ~hclk;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task chk32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: bus %h want %h", $time, g, e);
    end
  endtask : chk32
  task chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: pins %h want %h", $time, g, e);
    end
  endtask : chk8
  // bounded wait for hready; a hung slave ends the run
  task wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  // one single word transfer, read data lands in r
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= GPM_HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
    chk8({6'h0, hreadyout, hresp}, 8'h02);
  endtask : xfer
  // expected drive, enable, triggers and clock-in from the mirrors
  task chk_pins();
    logic [7:0] eoe, eout;
    logic [3:0] eseq;
    logic eclk;
    logic [2:0] s;
    #1;
    {eoe, eout, eseq, eclk} = '0;
    for (int i = 0; i < 8; i++) begin
      s = TBL[(i * 4 + int'(m_cfg[2 * i +: 2])) * 3 +: 3];
      case (gpm_src_e'(s))
        GPM_SRC_GPIO: {eoe[i], eout[i]} = {m_oen[i], m_out[i]};
        GPM_SRC_SYNC: {eoe[i], eout[i]} = {m_oen[i], sync[i]};
        GPM_SRC_IRQ0: {eoe[i], eout[i]} = {1'b1, irq0};
        GPM_SRC_IRQ1: {eoe[i], eout[i]} = {1'b1, irq1};
        GPM_SRC_POR: {eoe[i], eout[i]} = {1'b1, por};
        GPM_SRC_HIB: {eoe[i], eout[i]} = {1'b1, hib};
        GPM_SRC_TRIG: eseq[i % 4] = eseq[i % 4] | pin_in[i];
        default: eclk = eclk | pin_in[i];
      endcase
    end
    chk8(pin_oe, eoe);
    chk8(pin_out & eoe, eout & eoe);
    chk8({4'h0, seq_trigger}, {4'h0, eseq});
    chk8({7'h0, ext_clk}, {7'h0, eclk});
    @(posedge hclk);
  endtask : chk_pins
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, sync, irq0, irq1, por, hib, host_drive} = '0;
    {m_cfg, m_oen, m_out} = '0;
    hsize = 3'h2;
    host_en = 8'hff;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // every register, and one unmapped word, reads zero
    for (int o = 0; o <= 'h30; o += 4) begin
      xfer(1'b0, 8'(o), 32'h0);
      chk32(r, GPM_ZERO32);
    end
    chk_pins();
    // read-write registers other than the event config keep only their implemented bits
    repeat (4) begin
      for (k = 0; k < 5; k++) begin
        a = (k == 4) ? GPM_OFF_OUT : 8'(k * 4);
        d = rnd();
        xfer(1'b1, a, d);
        xfer(1'b0, a, 32'h0);
        chk32(r, d & (k == 0 ? 32'hffff : 32'hff));
      end
    end
    m_out = d[7:0];
    // set, clear, toggle touch only bits written as one
    repeat (12) begin
      d = rnd();
      k = int'(d[9:8]) % 3;
      a = 8'h18 + 8'(k * 4);
      xfer(1'b1, a, d);
      m_out = k == 0 ? m_out | d[7:0] : k == 1 ? m_out & ~d[7:0] : m_out ^ d[7:0];
      xfer(1'b0, a, 32'h0);
      chk32(r, GPM_ZERO32);
      xfer(1'b0, GPM_OFF_OUT, 32'h0);
      chk32(r, {24'h0, m_out});
    end
    // all pins on one code first, then random mixes
    for (int it = 0; it < 12; it++) begin
      d = rnd();
      m_cfg = it < 4 ? {8{it[1:0]}} : d[15:0];
      {m_oen, m_out} = d[31:16];
      d = rnd();
      {sync, host_drive, irq0, irq1, por, hib} <= d[19:0];
      xfer(1'b1, GPM_OFF_CFG, {16'h0, m_cfg});
      xfer(1'b1, GPM_OFF_OEN, {24'h0, m_oen});
      xfer(1'b1, GPM_OFF_OUT, {24'h0, m_out});
      chk_pins();
    end
    // nothing driven; input register gated by input path enable
    xfer(1'b1, GPM_OFF_CFG, 32'h33);
    xfer(1'b1, GPM_OFF_OEN, 32'h0);
    d = rnd();
    host_drive <= d[7:0];
    xfer(1'b1, GPM_OFF_IEN, {24'h0, d[15:8]});
    repeat (3) @(posedge hclk);
    xfer(1'b0, GPM_OFF_IN, 32'h0);
    chk32(r, {24'h0, d[7:0] & d[15:8]});
    // host lets go: only pulled pins are sure to read high
    host_en <= 8'h00;
    xfer(1'b1, GPM_OFF_IEN, 32'hff);
    xfer(1'b1, GPM_OFF_PULL, {24'h0, d[23:16]});
    repeat (3) @(posedge hclk);
    xfer(1'b0, GPM_OFF_IN, 32'h0);
    chk32(r & {24'h0, d[23:16]}, {24'h0, d[23:16]});
    chk8(pin_pull_en, d[23:16]);
    host_en <= 8'hff;
    host_drive <= 8'h00;
    // rising edge on pin 4 wakes and starts a sequence
    xfer(1'b1, GPM_OFF_EVCFG, 32'h000c_0000);
    repeat (3) @(posedge hclk);
    xfer(1'b1, GPM_OFF_EVCLR, 32'hff);
    host_drive <= 8'h10;
    k = 0;
    while (ev_wake !== 8'h10 && k < 20) begin
      @(posedge hclk);
      #1;
      k++;
    end
    if (ev_wake !== 8'h10) begin
      errors++;
      wrap_up();
    end
    chk8(ev_seq, 8'h10);
    @(posedge hclk);
    #1;
    chk8(ev_wake | ev_seq, 8'h00);
    @(posedge hclk);
    xfer(1'b0, GPM_OFF_EVFLG, 32'h0);
    chk32(r, 32'h10);
    xfer(1'b1, GPM_OFF_EVCLR, 32'h10);
    xfer(1'b0, GPM_OFF_EVFLG, 32'h0);
    chk32(r, GPM_ZERO32);
    // falling, both-edge and high-level modes on pins 4 to 6
    xfer(1'b1, GPM_OFF_EVCFG, 32'h0b65_0000);
    host_drive <= 8'h60;
    @(posedge hclk);
    #1;
    chk8(ev_wake, 8'h30);
    chk8(ev_seq, 8'h40);
    @(posedge hclk);
    #1;
    chk8(ev_wake, 8'h00);
    chk8(ev_seq, 8'h40);
    wrap_up();
  end
endmodule : testbench
